// ==== rtl/pas_map.svh ====
// Register offsets, field positions, reset values and sizes of the adder/subtracter
`ifndef PAS_MAP_SVH
`define PAS_MAP_SVH
`define PAS_W 16
`define PAS_RES_W 18
`define PAS_CARRY_BIT 16
`define PAS_RANGE_BIT 17
`define PAS_ADDR_W 8
`define PAS_OFS_OPA 8'h00
`define PAS_OFS_OPB 8'h04
`define PAS_OFS_CONST 8'h08
`define PAS_OFS_CFG 8'h0c
`define PAS_OFS_CTRL 8'h10
`define PAS_OFS_SYNCVAL 8'h14
`define PAS_OFS_RESULT 8'h18
`define PAS_CFG_W 8
`define PAS_CTRL_W 6
`define PAS_ASYNC_VAL 18'h00000
`define PAS_SYNC_RST 18'h00000
`define PAS_CFG_RST 8'h00
`define PAS_CTRL_RST 6'h10
`define PAS_OPD_RST 16'h0000
`endif

// ==== rtl/pas_pkg.sv ====
// Types and the shared arithmetic function of the adder/subtracter
`include "pas_map.svh"
package pas_pkg;
    typedef enum logic [1:0] {
        PAS_OP_ADD = 2'h0,
        PAS_OP_SUB = 2'h1,
        PAS_OP_ADDSUB = 2'h2
    } pas_op_t;
    typedef struct packed {
        logic reg_ovf;
        logic reg_carry;
        logic reg_result;
        logic use_const;
        logic has_carry;
        logic is_signed;
        pas_op_t operation_kind;
    } pas_cfg_t;
    typedef struct packed {
        logic async_preset;
        logic clk_en;
        logic sync_preset;
        logic load;
        logic carry_in;
        logic add_sel;
    } pas_ctrl_t;
    typedef struct packed {
        logic range_exceeded_flag;
        logic carry;
        logic [`PAS_W-1:0] sum;
    } pas_res_t;
    typedef enum logic [1:0] {
        PAS_ST_IDLE = 2'b01,
        PAS_ST_ACCESS = 2'b10
    } pas_st_t;

    // Subtraction runs as a + ~b + ~cin, so carry high means no borrow
    function automatic pas_res_t pas_compute(
        input logic [`PAS_W-1:0] a,
        input logic [`PAS_W-1:0] b,
        input logic cin,
        input logic add,
        input logic sgn
    );
        logic [`PAS_W:0] ext;
        logic [`PAS_W-1:0] bb;
        logic ci;
        pas_res_t r;
        bb = add ? b : ~b;
        ci = add ? cin : ~cin;
        ext = {1'b0, a} + {1'b0, bb} + {{`PAS_W{1'b0}}, ci};
        r.sum = ext[`PAS_W-1:0];
        r.carry = ext[`PAS_W];
        if (sgn) begin
            r.range_exceeded_flag = (a[`PAS_W-1] == bb[`PAS_W-1]) &&
                                    (ext[`PAS_W-1] != a[`PAS_W-1]);
        end else begin
            r.range_exceeded_flag = add ? ext[`PAS_W] : ~ext[`PAS_W];
        end
        return r;
    endfunction
endpackage

// ==== rtl/pas_datapath.sv ====
// Adder/subtracter core with its result, carry and overflow register
`include "pas_map.svh"
module pas_datapath (
    input wire logic ref_clk,
    input wire logic preset_n,
    input wire pas_pkg::pas_cfg_t cfg,
    input wire pas_pkg::pas_ctrl_t ctrl,
    input wire logic [15:0] opa,
    input wire logic [15:0] opb,
    input wire logic [15:0] cval,
    input wire pas_pkg::pas_res_t syncval,
    output pas_pkg::pas_res_t comb_res,
    output pas_pkg::pas_res_t reg_res
);
    import pas_pkg::*;

    typedef struct packed {
        pas_res_t rg;
    } pas_dp_state_t;

    pas_dp_state_t s;
    pas_dp_state_t next_s;
    logic add;
    logic cin;
    logic [`PAS_W-1:0] eff_b;

    always_comb begin
        case (cfg.operation_kind)
            PAS_OP_ADD: add = 1'b1;
            PAS_OP_SUB: add = 1'b0;
            default: add = ctrl.add_sel;
        endcase
        cin = cfg.has_carry ? ctrl.carry_in : ~add;
        eff_b = cfg.use_const ? cval : opb;
        comb_res = pas_compute(opa, eff_b, cin, add, cfg.is_signed);
        next_s = s;
        if (ctrl.clk_en) begin
            if (ctrl.sync_preset) begin
                next_s.rg = syncval;
            end else if (ctrl.load) begin
                next_s.rg = comb_res;
                next_s.rg.sum = eff_b;
            end else begin
                next_s.rg = comb_res;
            end
        end
    end

    // async preset forces the preset value
    always_ff @(posedge ref_clk or negedge preset_n) begin
        if (!preset_n) begin
            s <= `PAS_ASYNC_VAL;
        end else begin
            s <= next_s;
        end
    end

    assign reg_res = s.rg;
endmodule

// ==== rtl/pas_top.sv ====
// AHB-Lite wrapped parameterised adder/subtracter
`include "pas_map.svh"
// How it works
// - Add gives a+b+cin; subtract gives a-b-cin.
// - Select high adds, select low subtracts.
// - Select counts in add/subtract mode and in the unused mode code 3; fixed modes ignore it.
// - Without carry input, carry is 0 for add, 1 for subtract.
// - Constant operand, when enabled, replaces operand b.
// - Enabled, presets low: load takes b, otherwise the result.
// - Enable low holds all registered contents.
// - Registers change on the rising clock edge with enable high.
// - Async preset high forces the async value at once.
// - Registers start at the async value, zero by default.
// - Sync preset with enable loads the sync value, beating load.
// - Sync value defaults to zero when never written.
// - Presets act on result, carry and overflow registers alike.
// - Overflow is high when the result leaves the range.
// - Overflow follows signed or unsigned encoding.
// - Carry is the carry out of the top bit.
// - Carry and overflow are each either combinational or registered.
// - Registered result shows the register; otherwise the raw sum.
// - Any subset of result, carry and overflow may be registered.
// - A result output is always present.
module pas_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import pas_pkg::*;

    typedef struct packed {
        pas_st_t st;
        logic [`PAS_ADDR_W-1:0] addr;
        logic write;
        logic [`PAS_W-1:0] opa;
        logic [`PAS_W-1:0] opb;
        logic [`PAS_W-1:0] cval;
        pas_cfg_t cfg;
        pas_ctrl_t ctrl;
        pas_res_t syncval;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } pas_state_t;

    pas_state_t s;
    pas_state_t next_s;
    pas_res_t comb_res;
    pas_res_t reg_res;
    pas_res_t out_res;
    logic preset_n;
    logic take;

    assign preset_n = arst_n & ~s.ctrl.async_preset;

    pas_datapath i_pas_datapath (
        .ref_clk(ref_clk),
        .preset_n(preset_n),
        .cfg(s.cfg),
        .ctrl(s.ctrl),
        .opa(s.opa),
        .opb(s.opb),
        .cval(s.cval),
        .syncval(s.syncval),
        .comb_res(comb_res),
        .reg_res(reg_res)
    );

    always_comb begin
        // result from register or raw sum
        out_res.sum = s.cfg.reg_result ? reg_res.sum : comb_res.sum;
        out_res.carry = s.cfg.reg_carry ? reg_res.carry : comb_res.carry;
        out_res.range_exceeded_flag = s.cfg.reg_ovf ? reg_res.range_exceeded_flag
                                                    : comb_res.range_exceeded_flag;
    end

    // Only hsize word transfers are expected, so hsize is not decoded
    assign take = hsel && htrans[1] && hready;

    always_comb begin
        next_s = s;
        next_s.hresp = 1'b0;
        case (s.st)
            PAS_ST_IDLE: begin
                next_s.hreadyout = 1'b1;
                if (take) begin
                    next_s.st = PAS_ST_ACCESS;
                    next_s.addr = haddr[`PAS_ADDR_W-1:0];
                    next_s.write = hwrite;
                    next_s.hreadyout = 1'b0;
                end
            end
            PAS_ST_ACCESS: begin
                // One wait state lets hrdata leave a flip-flop
                next_s.st = PAS_ST_IDLE;
                next_s.hreadyout = 1'b1;
                next_s.hrdata = 32'h00000000;
                if (s.write) begin
                    case (s.addr)
                        `PAS_OFS_OPA: next_s.opa = hwdata[`PAS_W-1:0];
                        `PAS_OFS_OPB: next_s.opb = hwdata[`PAS_W-1:0];
                        `PAS_OFS_CONST: next_s.cval = hwdata[`PAS_W-1:0];
                        `PAS_OFS_CFG: next_s.cfg = pas_cfg_t'(hwdata[`PAS_CFG_W-1:0]);
                        `PAS_OFS_CTRL: next_s.ctrl = pas_ctrl_t'(hwdata[`PAS_CTRL_W-1:0]);
                        `PAS_OFS_SYNCVAL: next_s.syncval = pas_res_t'(hwdata[`PAS_RES_W-1:0]);
                        default: next_s.hresp = 1'b0;
                    endcase
                end else begin
                    case (s.addr)
                        `PAS_OFS_OPA: next_s.hrdata = 32'(s.opa);
                        `PAS_OFS_OPB: next_s.hrdata = 32'(s.opb);
                        `PAS_OFS_CONST: next_s.hrdata = 32'(s.cval);
                        `PAS_OFS_CFG: next_s.hrdata = 32'(s.cfg);
                        `PAS_OFS_CTRL: next_s.hrdata = 32'(s.ctrl);
                        `PAS_OFS_SYNCVAL: next_s.hrdata = 32'(s.syncval);
                        `PAS_OFS_RESULT: next_s.hrdata = 32'(out_res);
                        default: next_s.hrdata = 32'h00000000;
                    endcase
                end
            end
            default: begin
                next_s.st = PAS_ST_IDLE;
                next_s.hreadyout = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s.st <= PAS_ST_IDLE;
            s.addr <= 8'h00;
            s.write <= 1'b0;
            s.opa <= `PAS_OPD_RST;
            s.opb <= `PAS_OPD_RST;
            s.cval <= `PAS_OPD_RST;
            s.cfg <= `PAS_CFG_RST;
            // enable reads as set after reset
            s.ctrl <= `PAS_CTRL_RST;
            s.syncval <= `PAS_SYNC_RST;
            s.hrdata <= 32'h00000000;
            s.hreadyout <= 1'b1;
            s.hresp <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign hrdata = s.hrdata;

    // Helper values for the checks below
    logic [`PAS_W-1:0] chk_b;
    logic chk_add;
    logic chk_cin;
    assign chk_b = s.cfg.use_const ? s.cval : s.opb;
    assign chk_add = (s.cfg.operation_kind == PAS_OP_ADD) ||
                     ((s.cfg.operation_kind != PAS_OP_SUB) && s.ctrl.add_sel);
    assign chk_cin = s.cfg.has_carry ? s.ctrl.carry_in : ~chk_add;
    int chk_sdiff;
    assign chk_sdiff = int'($signed(s.opa)) - int'($signed(chk_b)) - int'(chk_cin);

    sequence s_access;
        hsel && htrans[1] && hready && hreadyout;
    endsequence
    sequence s_wait_then_ready;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_preset_busy;
        s.ctrl.async_preset && s.ctrl.clk_en;
    endsequence

    property p_bus_wait;
        @(posedge ref_clk) disable iff (!arst_n)
        s_access |=> s_wait_then_ready;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus wait state wrong");

    property p_add;
        @(posedge ref_clk) disable iff (!arst_n)
        chk_add |-> comb_res.sum == `PAS_W'(s.opa + chk_b + `PAS_W'(chk_cin));
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");

    property p_sub;
        @(posedge ref_clk) disable iff (!arst_n)
        !chk_add |-> comb_res.sum == `PAS_W'(s.opa - chk_b - `PAS_W'(chk_cin));
    endproperty
    a_sub: assert property (p_sub) else $error("subtract result wrong");

    property p_fixed_mode;
        @(posedge ref_clk) disable iff (!arst_n)
        s.cfg.operation_kind == PAS_OP_SUB && !s.cfg.has_carry
            |-> comb_res.sum == `PAS_W'(s.opa - chk_b - 16'h0001);
    endproperty
    a_fixed_mode: assert property (p_fixed_mode) else $error("fixed subtract wrong");

    property p_const;
        @(posedge ref_clk) disable iff (!arst_n)
        s.cfg.use_const && s.cfg.operation_kind == PAS_OP_ADD && !s.cfg.has_carry
            |-> comb_res.sum == `PAS_W'(s.opa + s.cval);
    endproperty
    a_const: assert property (p_const) else $error("constant operand unused");

    property p_load;
        @(posedge ref_clk) disable iff (!preset_n)
        s.ctrl.clk_en && !s.ctrl.sync_preset && s.ctrl.load ##1 preset_n
            |-> reg_res.sum == $past(chk_b);
    endproperty
    a_load: assert property (p_load) else $error("load did not take b");

    property p_capture;
        @(posedge ref_clk) disable iff (!preset_n)
        s.ctrl.clk_en && !s.ctrl.sync_preset && !s.ctrl.load
            |=> reg_res == $past(comb_res);
    endproperty
    a_capture: assert property (p_capture) else $error("result not captured");

    property p_hold;
        @(posedge ref_clk) disable iff (!preset_n)
        !s.ctrl.clk_en |=> $stable(reg_res);
    endproperty
    a_hold: assert property (p_hold) else $error("register moved while disabled");

    property p_async;
        @(posedge ref_clk) disable iff (!arst_n)
        s.ctrl.async_preset |-> reg_res == `PAS_ASYNC_VAL;
    endproperty
    a_async: assert property (p_async) else $error("async preset not held");

    property p_sync;
        @(posedge ref_clk) disable iff (!preset_n)
        s.ctrl.clk_en && s.ctrl.sync_preset |=> reg_res == $past(s.syncval);
    endproperty
    a_sync: assert property (p_sync) else $error("sync preset not loaded");

    property p_carry;
        @(posedge ref_clk) disable iff (!arst_n)
        chk_add |-> comb_res.carry ==
            (({1'b0, s.opa} + {1'b0, chk_b} + 17'(chk_cin)) >> `PAS_W);
    endproperty
    a_carry: assert property (p_carry) else $error("carry out wrong");

    property p_ovf_unsigned;
        @(posedge ref_clk) disable iff (!arst_n)
        !s.cfg.is_signed && chk_add |-> comb_res.range_exceeded_flag == comb_res.carry;
    endproperty
    a_ovf_unsigned: assert property (p_ovf_unsigned) else $error("unsigned overflow wrong");

    property p_ovf_signed;
        @(posedge ref_clk) disable iff (!arst_n)
        s.cfg.is_signed && chk_add && !chk_cin && s.opa[15] == chk_b[15]
            |-> comb_res.range_exceeded_flag == (comb_res.sum[15] != s.opa[15]);
    endproperty
    a_ovf_signed: assert property (p_ovf_signed) else $error("signed overflow wrong");

    property p_out_select;
        @(posedge ref_clk) disable iff (!arst_n)
        s.cfg.reg_result |-> out_res.sum == reg_res.sum;
    endproperty
    a_out_select: assert property (p_out_select) else $error("result output source");

    property p_fixed_add;
        @(posedge ref_clk) disable iff (!arst_n)
        s.cfg.operation_kind == PAS_OP_ADD |->
            comb_res.sum == `PAS_W'(s.opa + chk_b + `PAS_W'(s.cfg.has_carry & s.ctrl.carry_in));
    endproperty
    a_fixed_add: assert property (p_fixed_add) else $error("fixed add followed select");

    property p_power_up;
        @(posedge ref_clk)
        !arst_n ##1 !arst_n |-> reg_res == `PAS_ASYNC_VAL;
    endproperty
    a_power_up: assert property (p_power_up) else $error("register not at async value");

    property p_sync_zero;
        @(posedge ref_clk)
        !arst_n ##1 arst_n |-> s.syncval == `PAS_SYNC_RST;
    endproperty
    a_sync_zero: assert property (p_sync_zero) else $error("sync value not zero");

    property p_preset_all;
        @(posedge ref_clk) disable iff (!arst_n)
        s.ctrl.async_preset && s.cfg.reg_carry && s.cfg.reg_ovf |->
            {out_res.range_exceeded_flag, out_res.carry} == 2'(`PAS_ASYNC_VAL >> `PAS_CARRY_BIT);
    endproperty
    a_preset_all: assert property (p_preset_all) else $error("preset missed flags");

    property p_borrow;
        @(posedge ref_clk) disable iff (!arst_n)
        !chk_add |->
            comb_res.carry == ({1'b0, s.opa} >= ({1'b0, chk_b} + 17'(chk_cin)));
    endproperty
    a_borrow: assert property (p_borrow) else $error("subtract carry wrong");

    property p_uns_sub;
        @(posedge ref_clk) disable iff (!arst_n)
        !s.cfg.is_signed && !chk_add |-> comb_res.range_exceeded_flag == !comb_res.carry;
    endproperty
    a_uns_sub: assert property (p_uns_sub) else $error("unsigned borrow flag wrong");

    property p_sgn_sub;
        @(posedge ref_clk) disable iff (!arst_n)
        s.cfg.is_signed && !chk_add |->
            comb_res.range_exceeded_flag == (chk_sdiff > 32767 || chk_sdiff < -32768);
    endproperty
    a_sgn_sub: assert property (p_sgn_sub) else $error("signed subtract flag wrong");

    property p_carry_src;
        @(posedge ref_clk) disable iff (!arst_n)
        s.cfg.reg_carry |-> out_res.carry == reg_res.carry;
    endproperty
    a_carry_src: assert property (p_carry_src) else $error("carry not registered");

    property p_ovf_src;
        @(posedge ref_clk) disable iff (!arst_n)
        !s.cfg.reg_ovf |->
            out_res.range_exceeded_flag == comb_res.range_exceeded_flag;
    endproperty
    a_ovf_src: assert property (p_ovf_src) else $error("flag not combinational");

    property p_rd_result;
        @(posedge ref_clk) disable iff (!arst_n)
        s.st == PAS_ST_ACCESS && !s.write && s.addr == `PAS_OFS_RESULT
            |=> hrdata == 32'($past(out_res));
    endproperty
    a_rd_result: assert property (p_rd_result) else $error("result read wrong");

    property p_async_wins;
        @(posedge ref_clk) disable iff (!arst_n)
        s_preset_busy ##1 s_preset_busy |-> reg_res == `PAS_ASYNC_VAL;
    endproperty
    a_async_wins: assert property (p_async_wins) else $error("async preset lost");
endmodule

// ==== test/pas_ahb_master.sv ====
// AHB-Lite master model standing in for the surrounding user logic
module pas_ahb_master (
    input wire logic ref_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // One single word transfer; waits on the slave however long it takes
    task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic resp);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        haddr <= ~addr;
        hwdata <= wdata;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rdata = hrdata;
        resp = hresp;
        // Released data bus shows a changed pattern, never a stale copy
        hwdata <= ~wdata;
    endtask
endmodule

// ==== test/param_adder_subtracter_tb.sv ====
// Self-checking bench for the AHB-Lite adder/subtracter
`include "pas_map.svh"
module param_adder_subtracter_tb;
    import pas_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk;
    logic arst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    int errors;
    int total_checks;
    int cycles;

    localparam logic [7:0] c_cfg [9] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h0a, 8'h0e, 8'h05,
                                         8'h10, 8'h0b};
    localparam logic [5:0] c_ctrl [9] = '{6'h10, 6'h11, 6'h11, 6'h10, 6'h13, 6'h13, 6'h10,
                                          6'h10, 6'h10};
    localparam logic [15:0] c_a [9] = '{16'hffff, 16'h0005, 16'h1234, 16'h0003, 16'h7fff,
                                        16'h7fff, 16'h8000, 16'h0010, 16'h0005};
    localparam logic [15:0] c_b [9] = '{16'h0001, 16'h0003, 16'h1111, 16'h0005, 16'h0000,
                                        16'h0000, 16'h0000, 16'hffff, 16'h0005};

    pas_top i_pas_top (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata)
    );

    pas_ahb_master i_pas_ahb_master (
        .ref_clk(ref_clk),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata)
    );

    always #25 ref_clk = ~ref_clk;

    // Cut a hung handshake short well beyond the few hundred cycles needed
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] dummy;
        logic resp;
        i_pas_ahb_master.bus_xfer(1'b1, {24'h0, ofs}, d, dummy, resp);
        chk({31'h0, resp}, 32'h0);
    endtask

    task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] got;
        logic resp;
        i_pas_ahb_master.bus_xfer(1'b0, {24'h0, ofs}, 32'h5a5a_a5a5, got, resp);
        chk({31'h0, resp}, 32'h0);
        chk(got, exp);
    endtask

    // Reference arithmetic built on plain integers, independent of the design
    function automatic logic [31:0] expect_res(input logic [7:0] cfg, input logic [5:0] ctrl,
                                               input logic [15:0] a, input logic [15:0] b,
                                               input logic [15:0] c);
        logic [15:0] bb;
        logic add;
        logic ci;
        logic carry;
        logic ovf;
        int r;
        int rs;
        bb = cfg[4] ? c : b;
        add = cfg[1] ? ctrl[0] : ~cfg[0];
        ci = cfg[3] ? ctrl[1] : ~add;
        r = add ? int'(a) + int'(bb) + int'(ci) : int'(a) - int'(bb) - int'(ci);
        rs = add ? int'($signed(a)) + int'($signed(bb)) + int'(ci)
                 : int'($signed(a)) - int'($signed(bb)) - int'(ci);
        carry = add ? (r > 65535) : (r >= 0);
        ovf = cfg[2] ? (rs > 32767 || rs < -32768) : (add ? carry : ~carry);
        return {14'h0, ovf, carry, r[15:0]};
    endfunction

    task automatic t_reset_values();
        rd(`PAS_OFS_CFG, 32'h0000_0000);
        rd(`PAS_OFS_CTRL, 32'h0000_0010);
        rd(`PAS_OFS_SYNCVAL, 32'h0000_0000);
        rd(`PAS_OFS_RESULT, 32'h0000_0000);
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h1c, 32'h0000_0000);
        rd(`PAS_OFS_OPA, 32'h0000_0000);
    endtask

    task automatic t_comb_modes();
        for (int i = 0; i < 9; i++) begin
            wr(`PAS_OFS_OPA, {16'h0, c_a[i]});
            wr(`PAS_OFS_OPB, {16'h0, c_b[i]});
            wr(`PAS_OFS_CONST, 32'h0000_0020);
            wr(`PAS_OFS_CFG, {24'h0, c_cfg[i]});
            wr(`PAS_OFS_CTRL, {26'h0, c_ctrl[i]});
            rd(`PAS_OFS_RESULT, expect_res(c_cfg[i], c_ctrl[i], c_a[i], c_b[i], 16'h0020));
        end
    endtask

    task automatic t_registered();
        logic [31:0] exp;
        wr(`PAS_OFS_CFG, 32'h0000_00e0);
        wr(`PAS_OFS_CTRL, 32'h0000_0010);
        wr(`PAS_OFS_OPA, 32'h0000_8001);
        wr(`PAS_OFS_OPB, 32'h0000_8002);
        rd(`PAS_OFS_RESULT, 32'h0003_0003);
        wr(`PAS_OFS_CTRL, 32'h0000_0000);
        wr(`PAS_OFS_OPA, 32'h0000_0001);
        rd(`PAS_OFS_RESULT, 32'h0003_0003);
        wr(`PAS_OFS_CTRL, 32'h0000_0014);
        exp = expect_res(8'he0, 6'h14, 16'h0001, 16'h8002, 16'h0000);
        exp[15:0] = 16'h8002;
        rd(`PAS_OFS_RESULT, exp);
        wr(`PAS_OFS_SYNCVAL, 32'h0003_abcd);
        wr(`PAS_OFS_CTRL, 32'h0000_001c);
        rd(`PAS_OFS_RESULT, 32'h0003_abcd);
        wr(`PAS_OFS_CTRL, 32'h0000_0008);
        wr(`PAS_OFS_SYNCVAL, 32'h0001_2345);
        rd(`PAS_OFS_RESULT, 32'h0003_abcd);
        wr(`PAS_OFS_CTRL, 32'h0000_0038);
        rd(`PAS_OFS_RESULT, 32'h0000_0000);
        wr(`PAS_OFS_CTRL, 32'h0000_0010);
        rd(`PAS_OFS_RESULT, 32'h0000_8003);
        // Only the sum is held; carry and overflow follow the live operands
        wr(`PAS_OFS_CFG, 32'h0000_0020);
        wr(`PAS_OFS_CTRL, 32'h0000_0000);
        wr(`PAS_OFS_OPA, 32'h0000_ffff);
        wr(`PAS_OFS_OPB, 32'h0000_0001);
        rd(`PAS_OFS_RESULT, 32'h0003_8003);
    endtask

    initial begin
        ref_clk = 1'b0;
        arst_n = 1'b0;
        errors = 0;
        total_checks = 0;
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset_values();
        t_comb_modes();
        t_registered();
        wrap_up();
    end
endmodule
